//--- rtl/nvs_i2c_regs.svh
// Constants for the two-wire nonvolatile SRAM slave and its master.
`ifndef NVS_I2C_REGS_SVH
`define NVS_I2C_REGS_SVH
`define NVS_CLK_PERIOD_NS 50
`define NVS_SCL_PERIOD_NS 400
`define NVS_SCL_QTR_CYC ((`NVS_SCL_PERIOD_NS) / (4 * `NVS_CLK_PERIOD_NS))
`define NVS_T_FA_NS 20000000
`define NVS_RECALL_CYC ((`NVS_T_FA_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_MEM_SADDR 7'h50
`define NVS_CTL_SADDR 7'h18
`define NVS_BP_QTR_BASE 13'h1800
`define NVS_BP_HALF_BASE 13'h1000
`define NVS_CTL_MCR 8'h00
`define NVS_CTL_SN_LAST 8'h08
`define NVS_CTL_LAST 8'h0c
`define NVS_CTL_CMD 8'haa
`define NVS_MCR_SNL 6
`define NVS_MCR_BP_HI 3
`define NVS_MCR_BP_LO 2
`define NVS_MCR_RST 8'h00
`define NVS_SN_RST 64'h0000_0000_0000_0000
`define NVS_DEV_ID 32'h5a5a_0001
`define NVS_CMD_W 11
`define NVS_CMD_START 10
`define NVS_CMD_STOP 9
`define NVS_CMD_READ 8
`define NVS_FIFO_DEPTH 16
`endif

//--- rtl/nvs_pkg.sv
// Types shared by both ends of the two-wire link.
package nvs_pkg;
  typedef enum logic [2:0] {
    NVS_S_IDLE = 3'b000,
    NVS_S_DEVADDR = 3'b001,
    NVS_S_MADDR_HI = 3'b011,
    NVS_S_MADDR_LO = 3'b010,
    NVS_S_WDATA = 3'b110,
    NVS_S_RDATA = 3'b111,
    NVS_S_CADDR = 3'b101,
    NVS_S_IGNORE = 3'b100
  } nvs_slv_st_e;
  typedef enum logic [1:0] {
    NVS_P_OFF = 2'b00,
    NVS_P_RECALL = 2'b01,
    NVS_P_ON = 2'b11,
    NVS_P_STORE = 2'b10
  } nvs_pwr_st_e;
  typedef enum logic [1:0] {
    NVS_M_IDLE = 2'b00,
    NVS_M_START = 2'b01,
    NVS_M_BITS = 2'b11,
    NVS_M_STOP = 2'b10
  } nvs_mst_st_e;
endpackage

//--- rtl/nvs_i2c_if.sv
// Two-wire bus joining the master end and the memory end.
`timescale 1ns/1ps
`default_nettype none
interface nvs_i2c_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Open-drain lines with pull-ups: any enabled driver pulls the line low.
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);
  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

//--- rtl/nvs_slave.sv
// Memory end: two-wire slave with array, control registers and power sequencing.
// Notes on behaviour
// - Write-protect high rejects writes, counter held.
// - Supply loss blocks access, starts capacitor-powered store.
// - Store skipped when nothing written since store/recall.
// - Power-up recall copies cells; access blocked meanwhile.
// - Address byte low bit zero means write.
// - Write accepts bytes until stop, restart or nack.
// - Unknown slave address is not acknowledged.
// - Protected array write nacked, counter stays there.
// - Nonexistent address nacked at once, counter unchanged.
// - After a write nack, ignore until stop/restart.
// - Burst into read-only identifier area nacked there.
// - Data byte committed at its eighth bit.
// - Each successfully written byte is acknowledged.
// - Read drives data from current address.
// - Counter advances after every written byte except at the command address.
// - Array counter wraps to zero after last.
// - Control burst read wraps to address zero.
// - Master ends reads by nack or stop/restart.
// - Random read: address write then restart loads counter.
// - Block-protect field guards none, quarter, half, all.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_i2c_regs.svh"
module nvs_slave
  import nvs_pkg::*;
#(
  parameter int unsigned RECALL_CYC = `NVS_RECALL_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  nvs_i2c_if.slave bus,
  input wire logic power_good,
  input wire logic wp,
  output logic access_ready,
  output logic store_capacitor_pin,
  output logic recall_busy
);
  logic [7:0] sram [0:8191];
  logic [7:0] nv [0:8191];
  logic [3:0] in_s1_ff, in_s2_ff;
  logic scl_d_ff, sda_d_ff;
  nvs_slv_st_e st_ff, nxt_st;
  nvs_pwr_st_e pw_ff, nxt_pw;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic ack_ff, nxt_ack, oe_ff, nxt_oe, csel_ff, nxt_csel;
  logic [12:0] mptr_ff, nxt_mptr;
  logic [4:0] mhi_ff, nxt_mhi;
  logic [7:0] cptr_ff, nxt_cptr, mcr_ff, nxt_mcr;
  logic [63:0] sn_ff, nxt_sn;
  logic dirty_ff, wr_commit;
  logic [13:0] walk_ff, nxt_walk;
  logic [31:0] tmr_ff, nxt_tmr;
  logic ready_ff, cap_ff, rec_ff;

  function automatic logic bp_prot(input logic [1:0] bp, input logic [12:0] a);
    logic r;
    r = 1'b0;
    case (bp)
      2'b01: r = (a >= `NVS_BP_QTR_BASE);
      2'b10: r = (a >= `NVS_BP_HALF_BASE);
      2'b11: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] ctl_rd(input logic [7:0] a, input logic [7:0] mcr,
                                        input logic [63:0] sn);
    logic [7:0] r;
    logic [2:0] si;
    logic [1:0] ii;
    logic [31:0] id;
    r = 8'h00;
    si = 3'(a[2:0] - 3'h1);
    ii = 2'(`NVS_CTL_LAST - a);
    id = `NVS_DEV_ID;
    if (a == `NVS_CTL_MCR) begin
      r = mcr;
    end else if (a <= `NVS_CTL_SN_LAST) begin
      r = sn[{si, 3'h0} +: 8];
    end else if (a <= `NVS_CTL_LAST) begin
      r = id[{ii, 3'h0} +: 8];
    end
    return r;
  endfunction

  wire scl_s = in_s2_ff[0];
  wire sda_s = in_s2_ff[1];
  wire pg_s = in_s2_ff[2];
  wire wp_s = in_s2_ff[3];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire pwr_on = (pw_ff == NVS_P_ON);
  wire active = (st_ff != NVS_S_IDLE) && (st_ff != NVS_S_IGNORE);
  wire [7:0] byte_in = {sh_ff[6:0], sda_s};
  wire byte_done = scl_rise & active & (cnt_ff == 4'h7);
  wire hit_mem = (byte_in[7:1] == `NVS_MEM_SADDR);
  wire hit_ctl = (byte_in[7:1] == `NVS_CTL_SADDR);
  wire caddr_ok = (byte_in <= `NVS_CTL_LAST) || (byte_in == `NVS_CTL_CMD);
  wire serial_lock_bit = mcr_ff[`NVS_MCR_SNL];
  wire sn_area = (cptr_ff != `NVS_CTL_MCR) && (cptr_ff <= `NVS_CTL_SN_LAST);
  wire c_wr_ok = (cptr_ff == `NVS_CTL_MCR) || (cptr_ff == `NVS_CTL_CMD) || (sn_area && !serial_lock_bit);
  wire m_prot = bp_prot(mcr_ff[`NVS_MCR_BP_HI:`NVS_MCR_BP_LO], mptr_ff);
  wire wr_ok = pwr_on & ~wp_s & (csel_ff ? c_wr_ok : ~m_prot);
  wire mem_we = byte_done & (st_ff == NVS_S_WDATA) & ~csel_ff & wr_ok;
  wire [7:0] c_eff = (cptr_ff <= `NVS_CTL_LAST) ? cptr_ff : `NVS_CTL_MCR;
  wire [7:0] rd_byte = csel_ff ? ctl_rd(c_eff, mcr_ff, sn_ff) : sram[mptr_ff];
  wire [2:0] wr_si = 3'(cptr_ff[2:0] - 3'h1);

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ack = ack_ff;
    nxt_oe = oe_ff;
    nxt_csel = csel_ff;
    nxt_mptr = mptr_ff;
    nxt_mhi = mhi_ff;
    nxt_cptr = cptr_ff;
    nxt_mcr = mcr_ff;
    nxt_sn = sn_ff;
    wr_commit = 1'b0;
    if (start_ev) begin
      nxt_st = NVS_S_DEVADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_ack = 1'b0;
    end else if (stop_ev) begin
      nxt_st = NVS_S_IDLE;
      nxt_oe = 1'b0;
      nxt_ack = 1'b0;
    end else if (scl_rise && active) begin
      nxt_cnt = (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
      if (st_ff != NVS_S_RDATA) begin
        nxt_sh = byte_in;
      end
      if (cnt_ff == 4'h8 && st_ff == NVS_S_RDATA && sda_s) begin
        nxt_st = NVS_S_IGNORE;
      end
      if (cnt_ff == 4'h7) begin
        nxt_st = NVS_S_IGNORE;
        case (st_ff)
          NVS_S_DEVADDR: begin
            if ((hit_mem || hit_ctl) && pwr_on) begin
              nxt_ack = 1'b1;
              nxt_csel = hit_ctl;
              if (byte_in[0]) begin
                nxt_st = NVS_S_RDATA;
              end else begin
                nxt_st = hit_ctl ? NVS_S_CADDR : NVS_S_MADDR_HI;
              end
            end
          end
          NVS_S_MADDR_HI: begin
            if (byte_in[7:5] == 3'h0) begin
              nxt_ack = 1'b1;
              nxt_mhi = byte_in[4:0];
              nxt_st = NVS_S_MADDR_LO;
            end
          end
          NVS_S_MADDR_LO: begin
            nxt_ack = 1'b1;
            nxt_mptr = {mhi_ff, byte_in};
            nxt_st = NVS_S_WDATA;
          end
          NVS_S_CADDR: begin
            if (caddr_ok) begin
              nxt_ack = 1'b1;
              nxt_cptr = byte_in;
              nxt_st = NVS_S_WDATA;
            end
          end
          NVS_S_WDATA: begin
            if (wr_ok) begin
              nxt_ack = 1'b1;
              nxt_st = NVS_S_WDATA;
              wr_commit = 1'b1;
              if (!csel_ff) begin
                nxt_mptr = mptr_ff + 13'h1;
              end else if (cptr_ff == `NVS_CTL_MCR) begin
                nxt_mcr = `NVS_MCR_RST;
                nxt_mcr[`NVS_MCR_SNL] = serial_lock_bit | byte_in[`NVS_MCR_SNL];
                nxt_mcr[`NVS_MCR_BP_HI:`NVS_MCR_BP_LO] = byte_in[`NVS_MCR_BP_HI:`NVS_MCR_BP_LO];
                nxt_cptr = cptr_ff + 8'h1;
              end else if (cptr_ff != `NVS_CTL_CMD) begin
                nxt_sn[{wr_si, 3'h0} +: 8] = byte_in;
                nxt_cptr = cptr_ff + 8'h1;
              end
            end
          end
          NVS_S_RDATA: nxt_st = NVS_S_RDATA;
          default: nxt_st = NVS_S_IGNORE;
        endcase
      end
    end else if (scl_fall && active) begin
      if (cnt_ff == 4'h8) begin
        nxt_oe = ack_ff;
        nxt_ack = 1'b0;
      end else if (cnt_ff == 4'h0) begin
        nxt_oe = 1'b0;
        if (st_ff == NVS_S_RDATA && !pwr_on) begin
          nxt_st = NVS_S_IGNORE;
        end else if (st_ff == NVS_S_RDATA) begin
          nxt_oe = ~rd_byte[7];
          nxt_sh = {rd_byte[6:0], 1'b0};
          if (csel_ff) begin
            nxt_cptr = (c_eff == `NVS_CTL_LAST) ? `NVS_CTL_MCR : c_eff + 8'h1;
          end else begin
            nxt_mptr = mptr_ff + 13'h1;
          end
        end
      end else if (st_ff == NVS_S_RDATA) begin
        nxt_oe = ~sh_ff[7];
        nxt_sh = {sh_ff[6:0], 1'b0};
      end
    end
  end

  always_comb begin
    nxt_pw = pw_ff;
    nxt_walk = walk_ff[13] ? walk_ff : walk_ff + 14'h1;
    nxt_tmr = tmr_ff;
    case (pw_ff)
      NVS_P_OFF: begin
        nxt_walk = 14'h0;
        nxt_tmr = 32'h0;
        if (pg_s) begin
          nxt_pw = NVS_P_RECALL;
        end
      end
      NVS_P_RECALL: begin
        nxt_tmr = tmr_ff + 32'h1;
        if (!pg_s) begin
          nxt_pw = NVS_P_OFF;
        end else if (walk_ff[13] && tmr_ff >= 32'(RECALL_CYC - 1)) begin
          nxt_pw = NVS_P_ON;
        end
      end
      NVS_P_ON: begin
        nxt_walk = 14'h0;
        if (!pg_s) begin
          nxt_pw = dirty_ff ? NVS_P_STORE : NVS_P_OFF;
        end
      end
      default: begin
        if (walk_ff[13]) begin
          nxt_pw = NVS_P_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_s1_ff <= 4'h3;
      in_s2_ff <= 4'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      in_s1_ff <= {wp, power_good, bus.sda, bus.scl};
      in_s2_ff <= in_s1_ff;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= NVS_S_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ack_ff <= 1'b0;
      oe_ff <= 1'b0;
      csel_ff <= 1'b0;
      mptr_ff <= 13'h0;
      mhi_ff <= 5'h0;
      cptr_ff <= `NVS_CTL_MCR;
      mcr_ff <= `NVS_MCR_RST;
      sn_ff <= `NVS_SN_RST;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ack_ff <= nxt_ack;
      oe_ff <= nxt_oe;
      csel_ff <= nxt_csel;
      mptr_ff <= nxt_mptr;
      mhi_ff <= nxt_mhi;
      cptr_ff <= nxt_cptr;
      mcr_ff <= nxt_mcr;
      sn_ff <= nxt_sn;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pw_ff <= NVS_P_OFF;
      walk_ff <= 14'h0;
      tmr_ff <= 32'h0;
      dirty_ff <= 1'b0;
      ready_ff <= 1'b0;
      cap_ff <= 1'b0;
      rec_ff <= 1'b0;
    end else begin
      pw_ff <= nxt_pw;
      walk_ff <= nxt_walk;
      tmr_ff <= nxt_tmr;
      if (wr_commit) begin
        dirty_ff <= 1'b1;
      end else if (pw_ff != NVS_P_ON && pw_ff != nxt_pw) begin
        dirty_ff <= 1'b0;
      end
      ready_ff <= (nxt_pw == NVS_P_ON);
      cap_ff <= (nxt_pw == NVS_P_STORE);
      rec_ff <= (nxt_pw == NVS_P_RECALL);
    end
  end

  // Array and nonvolatile copy carry no reset; recall and store walk them word by word.
  always_ff @(posedge sys_clk) begin
    if (pw_ff == NVS_P_RECALL && !walk_ff[13]) begin
      sram[walk_ff[12:0]] <= nv[walk_ff[12:0]];
    end else if (mem_we) begin
      sram[mptr_ff] <= byte_in;
    end
    if (pw_ff == NVS_P_STORE && !walk_ff[13]) begin
      nv[walk_ff[12:0]] <= sram[walk_ff[12:0]];
    end
  end

  assign bus.s_sda_oe = oe_ff;
  assign access_ready = ready_ff;
  assign store_capacitor_pin = cap_ff;
  assign recall_busy = rec_ff;
endmodule
`default_nettype wire

//--- rtl/nvs_master.sv
// Master end: command FIFO and two-wire bit engine.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_i2c_regs.svh"
module nvs_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic full_n_ff, valid_ff;
  wire push = in_valid & full_n_ff;
  wire pop = out_ready & valid_ff;
  wire [AW:0] nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      full_n_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      wp_ff <= push ? AW'(wp_ff + 1'b1) : wp_ff;
      rp_ff <= pop ? AW'(rp_ff + 1'b1) : rp_ff;
      cnt_ff <= nxt_cnt;
      full_n_ff <= (nxt_cnt != (AW+1)'(D));
      valid_ff <= (nxt_cnt != '0);
    end
  end

  assign in_ready = full_n_ff;
  assign out_valid = valid_ff;
  assign out_data = mem[rp_ff];
endmodule

module nvs_master
  import nvs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  nvs_i2c_if.master bus,
  input wire logic cmd_valid,
  input wire logic [`NVS_CMD_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic bus_busy
);
  localparam logic [3:0] QTR = 4'(`NVS_SCL_QTR_CYC);
  nvs_mst_st_e st_ff, nxt_st;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit, div_ff;
  logic [`NVS_CMD_W-1:0] word_ff, nxt_word, f_word;
  logic [7:0] sh_ff, nxt_sh, rdat_ff, nxt_rdat;
  logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic rv_ff, nxt_rv, rack_ff, nxt_rack, busy_ff, f_valid;
  logic sda_s1_ff, sda_s2_ff;
  wire tick = (div_ff == QTR - 4'h1);
  wire f_pop = (st_ff == NVS_M_IDLE) & f_valid;
  wire is_rd = word_ff[`NVS_CMD_READ];
  wire is_last = word_ff[`NVS_CMD_STOP];

  nvs_fifo #(.W(`NVS_CMD_W), .D(`NVS_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_word)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_word = word_ff;
    nxt_sh = sh_ff;
    nxt_rdat = rdat_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rv = 1'b0;
    nxt_rack = rack_ff;
    if (f_pop) begin
      nxt_word = f_word;
      nxt_sh = f_word[7:0];
      nxt_bit = 4'h0;
      nxt_ph = 2'h0;
      nxt_st = f_word[`NVS_CMD_START] ? NVS_M_START : NVS_M_BITS;
    end else if (tick && st_ff != NVS_M_IDLE) begin
      nxt_ph = ph_ff + 2'h1;
      case (st_ff)
        NVS_M_START: begin
          case (ph_ff)
            2'h0: nxt_sda_oe = 1'b0;
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b1;
            default: begin
              nxt_scl_oe = 1'b1;
              nxt_st = NVS_M_BITS;
            end
          endcase
        end
        NVS_M_BITS: begin
          case (ph_ff)
            2'h0: begin
              if (bit_ff != 4'h8) begin
                nxt_sda_oe = is_rd ? 1'b0 : ~sh_ff[7];
              end else begin
                nxt_sda_oe = is_rd & ~is_last;
              end
            end
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_scl_oe = 1'b0;
            default: begin
              nxt_scl_oe = 1'b1;
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff != 4'h8) begin
                nxt_sh = {sh_ff[6:0], sda_s2_ff};
              end else begin
                nxt_rv = 1'b1;
                nxt_rdat = sh_ff;
                nxt_rack = ~sda_s2_ff;
                nxt_st = is_last ? NVS_M_STOP : NVS_M_IDLE;
              end
            end
          endcase
        end
        default: begin
          case (ph_ff)
            2'h0: nxt_sda_oe = 1'b1;
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b0;
            default: nxt_st = NVS_M_IDLE;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= NVS_M_IDLE;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      div_ff <= 4'h0;
      word_ff <= '0;
      sh_ff <= 8'h00;
      rdat_ff <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rv_ff <= 1'b0;
      rack_ff <= 1'b0;
      busy_ff <= 1'b0;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      div_ff <= tick ? 4'h0 : div_ff + 4'h1;
      word_ff <= nxt_word;
      sh_ff <= nxt_sh;
      rdat_ff <= nxt_rdat;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      rv_ff <= nxt_rv;
      rack_ff <= nxt_rack;
      busy_ff <= (nxt_st != NVS_M_IDLE);
      sda_s1_ff <= bus.sda;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
  assign rsp_valid = rv_ff;
  assign rsp_data = rdat_ff;
  assign rsp_ack = rack_ff;
  assign bus_busy = busy_ff;
endmodule
`default_nettype wire

//--- sim/nvs_link_chk.sv
// Checker watching the two-wire lines between the master end and the memory end.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_i2c_regs.svh"
module nvs_link_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_ff;
  logic sda_q_ff;
  logic first_ff;
  logic [3:0] cnt_ff;
  logic [7:0] byte_ff;
  wire start_w = scl && scl_q_ff && sda_q_ff && !sda;
  wire stop_w = scl && scl_q_ff && !sda_q_ff && sda;
  wire rise_w = scl && !scl_q_ff;
  wire ack_w = rise_w && first_ff && cnt_ff == 4'h8;
  wire bad_w = byte_ff[7:1] != `NVS_MEM_SADDR && byte_ff[7:1] != `NVS_CTL_SADDR;
  // Tracks the bit position and the first byte after each start.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      first_ff <= 1'b0;
      cnt_ff <= 4'h0;
      byte_ff <= 8'h00;
    end else begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
      if (start_w) begin
        cnt_ff <= 4'h0;
        first_ff <= 1'b1;
      end else if (rise_w && cnt_ff == 4'h8) begin
        cnt_ff <= 4'h0;
        first_ff <= 1'b0;
      end else if (rise_w) begin
        cnt_ff <= cnt_ff + 4'h1;
        byte_ff <= {byte_ff[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  scl_high_a: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*4] ##1 scl)
    else $error("clock low phase wrong");
  start_hold_a: assert property (start_w |-> ##1 scl ##1 !scl)
    else $error("start framing wrong");
  stop_idle_a: assert property (stop_w |-> (sda && scl && !s_sda_oe) [*4])
    else $error("bus not idle after stop");
  slave_edge_a: assert property ($changed(s_sda_oe) |-> !scl || !$past(scl))
    else $error("slave moved data while clock high");
  slave_release_a: assert property ($rose(s_sda_oe) |-> ##[1:100] !s_sda_oe)
    else $error("slave holds data line");
  addr_nack_a: assert property (ack_w && bad_w |-> sda)
    else $error("unknown address acknowledged");
  sda_stable_a: assert property (rise_w && cnt_ff != 4'h0 |-> ##1 $stable(sda) [*3])
    else $error("data changed while clock high");
  start_c: cover property (start_w);
  ack_c: cover property (ack_w && !sda);
  stop_c: cover property (stop_w);
endmodule
`default_nettype wire

//--- sim/nv_sram_i2c_slave_access_tb_top.sv
// Testbench joining master and memory ends with a queue-based reference model.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_i2c_regs.svh"
module nv_sram_i2c_slave_access_tb_top;
  import nvs_pkg::*;
  localparam logic [10:0] S = 11'h400, P = 11'h200, R = 11'h100;
  localparam logic [7:0] MW = {`NVS_MEM_SADDR, 1'b0}, MR = {`NVS_MEM_SADDR, 1'b1};
  localparam logic [7:0] CW = {`NVS_CTL_SADDR, 1'b0}, CR = {`NVS_CTL_SADDR, 1'b1};
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_good = 1'b0;
  logic wp = 1'b0;
  logic cmd_valid = 1'b0;
  logic [10:0] cmd_data = 11'h000;
  logic cmd_ready, rsp_valid, rsp_ack, bus_busy, access_ready, store_capacitor_pin, recall_busy;
  logic [7:0] rsp_data;
  logic [7:0] wd;
  logic [7:0] mem [int];
  logic refused = 1'b0;
  logic pr;
  logic [10:0] qw [$];
  logic qa [$];
  int qd [$];
  int ctl [13];
  int pa [3] = '{32'h5, 32'h1000, 32'h1800};
  int mismatches = 0, checks = 0, cyc = 0, i, b;
  nvs_i2c_if bus_if ();
  nvs_master nvs_master_inst (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus_if.master),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack), .bus_busy(bus_busy));
  nvs_slave #(.RECALL_CYC(16)) nvs_slave_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus(bus_if.slave), .power_good(power_good), .wp(wp), .access_ready(access_ready),
    .store_capacitor_pin(store_capacitor_pin), .recall_busy(recall_busy));
  nvs_link_chk nvs_link_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .m_scl_oe(bus_if.m_scl_oe), .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic c, input string m);
    checks++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function automatic int expv(input logic c, input int a);
    if (c) return ctl[a % 13];
    return mem.exists(a % 8192) ? int'(mem[a % 8192]) : -1;
  endfunction
  task automatic add(input logic [10:0] w, input logic a, input int d);
    qw.push_back(w);
    qa.push_back(a);
    qd.push_back(d);
  endtask
  task automatic maddr(input int a);
    add(S | MW, 1'b1, -1);
    add(11'(a[15:8]), 1'b1, -1);
    add(11'(a[7:0]), 1'b1, -1);
  endtask
  task automatic rd(input logic c, input int a, input int n);
    add(S | (c ? CR : MR), 1'b1, -1);
    for (int j = 0; j < n; j++) add(R | (j == n - 1 ? P : 11'h0), j != n - 1, expv(c, a + j));
  endtask
  task automatic push(input logic [10:0] w);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_data = w;
    while (cmd_ready !== 1'b1) begin
      refused = 1'b1;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task automatic get(input logic ea, input int ed);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 3000 && rsp_ack === ea && (ed < 0 || rsp_data === ed[7:0]), "response differs");
    @(negedge sys_clk);
  endtask
  // Pushes the queued words while collecting one response per word.
  task automatic run();
    int k;
    k = qw.size();
    fork
      begin
        foreach (qw[j]) push(qw[j]);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
      end
      for (int j = 0; j < k; j++) get(qa[j], qd[j]);
    join
    repeat (12) @(negedge sys_clk);
    chk(bus_busy === 1'b0, "engine busy after stop");
    qw.delete();
    qa.delete();
    qd.delete();
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 20000 && access_ready !== 1'b1; n++) @(negedge sys_clk);
    chk(access_ready === 1'b1 && recall_busy === 1'b0, "no access after recall");
  endtask
  initial begin
    void'($urandom(32'h73451a30));
    ctl = '{default: 0};
    for (i = 0; i < 4; i++) ctl[9 + i] = (`NVS_DEV_ID >> (24 - 8 * i)) & 32'hff;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    power_good = 1'b1;
    add(S | P | MW, 1'b0, -1);
    run();
    chk(recall_busy === 1'b1, "recall not running");
    wait_ready();
    maddr(32'h1ffc);
    for (i = 0; i < 20; i++) begin
      wd = $urandom;
      mem[(8188 + i) % 8192] = wd;
      add((i == 19 ? P : 11'h0) | wd, 1'b1, -1);
    end
    run();
    chk(refused, "queue never full");
    maddr(32'h1ffc);
    rd(1'b0, 32'h1ffc, 19);
    add(S | MW, 1'b1, -1);
    add(11'h20, 1'b0, -1);
    add(P | 11'h00, 1'b0, -1);
    rd(1'b0, 32'h000f, 1);
    run();
    for (i = 0; i < 3; i++) begin
      do b = $urandom_range(127); while (b == `NVS_MEM_SADDR || b == `NVS_CTL_SADDR);
      add(S | P | 11'({b[6:0], i[0]}), 1'b0, -1);
    end
    run();
    wp = 1'b1;
    maddr(32'h3);
    add(P | 11'h55, 1'b0, -1);
    run();
    wp = 1'b0;
    maddr(32'h3);
    rd(1'b0, 32'h3, 1);
    run();
    for (b = 0; b < 4; b++) begin
      add(S | CW, 1'b1, -1);
      add(11'h0, 1'b1, -1);
      add(P | 11'(b << 2), 1'b1, -1);
      ctl[0] = b << 2;
      foreach (pa[j]) begin
        maddr(pa[j]);
        wd = $urandom;
        pr = b == 3 || (b == 2 && pa[j] >= 32'h1000) || (b == 1 && pa[j] >= 32'h1800);
        add(P | wd, !pr, -1);
        if (!pr) mem[pa[j]] = wd;
        if (pr) rd(1'b0, pa[j], 1);
      end
      run();
    end
    add(S | CW, 1'b1, -1);
    add(11'h1, 1'b1, -1);
    for (i = 1; i < 10; i++) begin
      wd = $urandom;
      add((i == 9 ? P : 11'h0) | wd, i < 9, -1);
      if (i < 9) ctl[i] = wd;
    end
    rd(1'b1, 9, 6);
    add(S | CW, 1'b1, -1);
    add(11'haa, 1'b1, -1);
    add(P | 11'h00, 1'b1, -1);
    rd(1'b1, 0, 1);
    run();
    power_good = 1'b0;
    for (i = 0; i < 200 && store_capacitor_pin !== 1'b1; i++) @(negedge sys_clk);
    chk(store_capacitor_pin === 1'b1 && access_ready === 1'b0, "no store on loss");
    for (i = 0; i < 20000 && store_capacitor_pin !== 1'b0; i++) @(negedge sys_clk);
    power_good = 1'b1;
    wait_ready();
    maddr(32'h1ffc);
    rd(1'b0, 32'h1ffc, 20);
    run();
    power_good = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk(store_capacitor_pin === 1'b0 && access_ready === 1'b0, "needless store");
    close_out();
  end
endmodule
`default_nettype wire
